// ---- hw/pac_acq_ctrl.sv ----
// Purpose: Pretrigger multi-conversion acquisition control with APB registers
// Assumes: Converter raises adc_busy while converting and pulses adc_done with adc_data
// Notes:   Zero-wait APB slave; conversions before the stop edge stay as pretrigger data
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module pac_acq_ctrl
   import pac_pkg::*;
(
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic [7:0]        paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Trigger and clock pins
   input  wire logic              start_trigger_input_n,
   input  wire logic              stop_trigger_input,
   input  wire logic              fifth_source_input,
   // Converter
   input  wire logic              adc_busy,
   input  wire logic              adc_done,
   input  wire logic [DATA_W-1:0] adc_data,
   output logic                   convert_pulse,
   // Front-end selection and activity
   output logic [1:0]             gain_sel,
   output logic [3:0]             channel_sel,
   output logic                   acq_active
);
   pac_fifo_if f();
   logic [NUM_TB-1:0] tick;

   // Decoding of a mode word's source field, used for the interval counter
   function automatic logic src_tick(input logic [15:0] mode, input logic [NUM_TB-1:0] tk,
                                     input logic edge_in);
      logic r;
      r = 1'b0;
      case (mode[SRC_HI:SRC_LO])
         SRC_1MHZ:  r = tk[0];
         SRC_100K:  r = tk[1];
         SRC_10K:   r = tk[2];
         SRC_1K:    r = tk[3];
         SRC_100HZ: r = tk[4];
         SRC_FIFTH: r = edge_in;
         default:   r = 1'b0;
      endcase
      return r;
   endfunction : src_tick

   // Address map check, used for the error answer
   function automatic logic is_mapped(input logic [7:0] a);
      return (a == ADDR_STATUS) || (a == ADDR_CTRL) || (a == ADDR_START) || (a == ADDR_CLEAR) ||
             (a == ADDR_FIFO) || (a == ADDR_MUXGAIN) || (a == ADDR_IV_MODE) || (a == ADDR_IV_LOAD) ||
             (a == ADDR_LO_MODE) || (a == ADDR_LO_LOAD) || (a == ADDR_HI_MODE) || (a == ADDR_HI_LOAD);
   endfunction : is_mapped

   pac_tbase u_tbase (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick)
   );

   pac_fifo u_fifo (
      .pclk    (pclk),
      .presetn (presetn),
      .f       (f.buf_side)
   );

   // State
   pac_state_type st_ff, nxt_st;
   logic [15:0] iv_mode_ff, iv_load_ff, lo_mode_ff, lo_load_ff, hi_mode_ff, hi_load_ff;
   logic [15:0] nxt_iv_mode, nxt_iv_load, nxt_lo_mode, nxt_lo_load, nxt_hi_mode, nxt_hi_load;
   logic [15:0] iv_cnt_ff, lo_cnt_ff, hi_cnt_ff, nxt_iv_cnt, nxt_lo_cnt, nxt_hi_cnt;
   logic [1:0]  gain_ff, nxt_gain;
   logic [3:0]  chan_ff, nxt_chan;
   logic        cnt32_ff, nxt_cnt32;
   logic        gate_ff, nxt_gate;
   logic        ovfl_ff, nxt_ovfl, ovrn_ff, nxt_ovrn;
   logic        conv_ff, nxt_conv, act_ff, nxt_act;
   logic        stop_prev_ff, start_prev_ff, src_prev_ff;
   logic [31:0] prdata_ff, nxt_prdata;
   logic        pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;

   // Bus qualifiers and acquisition events
   logic        setup, wr_acc, rd_acc, ok_acc;
   logic        start_req, stop_edge, src_edge, base_tick;
   logic        conv_fire, gate_ok, counted, done, ovfl_set, ovrn_set, clr_wr;

   assign setup  = psel && !penable;
   assign ok_acc = psel && penable && pready_ff && !pslverr_ff;
   assign wr_acc = ok_acc && pwrite;
   assign rd_acc = ok_acc && !pwrite;
   assign clr_wr = wr_acc && (paddr == ADDR_CLEAR);

   // Edge detection on synchronous pins; previous values reset high
   assign stop_edge = stop_trigger_input && !stop_prev_ff;
   assign src_edge  = fifth_source_input && !src_prev_ff;
   assign start_req = (wr_acc && (paddr == ADDR_START) && (pwdata[15:0] == WORD_RST)) ||
                      (start_prev_ff && !start_trigger_input_n);

   assign base_tick = src_tick(iv_mode_ff, tick, src_edge);
   assign conv_fire = (st_ff == ACQ_RUN) && base_tick && (iv_cnt_ff == ONE16);
   assign gate_ok   = (lo_mode_ff[GATE_HI:GATE_LO] == GATE_LEVEL_HIGH) ? gate_ff : 1'b1;
   assign counted   = conv_fire && gate_ok;
   // cascaded: end only when both halves spent; single: end when the low count is 1
   assign done      = counted && (cnt32_ff ? (lo_cnt_ff == WORD_RST && hi_cnt_ff == WORD_RST)
                                           : (lo_cnt_ff == ONE16));
   assign ovfl_set  = adc_done && f.full;
   assign ovrn_set  = conv_fire && adc_busy;

   // results into buffer, popped by reads
   assign f.push      = adc_done && !f.full;
   assign f.push_data = adc_data;
   assign f.pop       = rd_acc && (paddr == ADDR_FIFO) && !f.empty;
   assign f.flush     = clr_wr && (pwdata[15:0] == WORD_RST);

   // Configuration registers written by software
   always_comb begin
      nxt_iv_mode = iv_mode_ff;
      nxt_iv_load = iv_load_ff;
      nxt_lo_mode = lo_mode_ff;
      nxt_lo_load = lo_load_ff;
      nxt_hi_mode = hi_mode_ff;
      nxt_hi_load = hi_load_ff;
      nxt_gain    = gain_ff;
      nxt_chan    = chan_ff;
      nxt_cnt32   = cnt32_ff;
      if (wr_acc) begin
         case (paddr)
            ADDR_IV_MODE: nxt_iv_mode = pwdata[15:0];
            ADDR_IV_LOAD: nxt_iv_load = pwdata[15:0];
            ADDR_LO_MODE: nxt_lo_mode = pwdata[15:0];
            ADDR_LO_LOAD: nxt_lo_load = pwdata[15:0];
            ADDR_HI_MODE: nxt_hi_mode = pwdata[15:0];
            ADDR_HI_LOAD: nxt_hi_load = pwdata[15:0];
            ADDR_CTRL:    nxt_cnt32 = pwdata[CTRL_CNT32];
            ADDR_MUXGAIN: begin
               nxt_gain = pwdata[GAIN_HI:GAIN_LO];
               nxt_chan = pwdata[CHAN_HI:0];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         iv_mode_ff <= WORD_RST;
         iv_load_ff <= WORD_RST;
         lo_mode_ff <= WORD_RST;
         lo_load_ff <= WORD_RST;
         hi_mode_ff <= WORD_RST;
         hi_load_ff <= WORD_RST;
         gain_ff    <= 2'h0;
         chan_ff    <= 4'h0;
         cnt32_ff   <= 1'b0;
      end else begin
         iv_mode_ff <= nxt_iv_mode;
         iv_load_ff <= nxt_iv_load;
         lo_mode_ff <= nxt_lo_mode;
         lo_load_ff <= nxt_lo_load;
         hi_mode_ff <= nxt_hi_mode;
         hi_load_ff <= nxt_hi_load;
         gain_ff    <= nxt_gain;
         chan_ff    <= nxt_chan;
         cnt32_ff   <= nxt_cnt32;
      end
   end

   // Acquisition sequencing; counters load from their load registers at start
   always_comb begin
      nxt_st     = st_ff;
      nxt_iv_cnt = iv_cnt_ff;
      nxt_lo_cnt = lo_cnt_ff;
      nxt_hi_cnt = hi_cnt_ff;
      nxt_gate   = gate_ff;
      nxt_conv   = 1'b0;
      nxt_ovfl   = ovfl_ff;
      nxt_ovrn   = ovrn_ff;
      // clear write drops both flags, a same-cycle error still sets
      if (clr_wr) begin
         nxt_ovfl = 1'b0;
         nxt_ovrn = 1'b0;
      end
      if (ovfl_set) nxt_ovfl = 1'b1;
      if (ovrn_set) nxt_ovrn = 1'b1;
      unique case (st_ff)
         ACQ_IDLE: begin
            if (start_req) begin
               nxt_st     = ACQ_RUN;
               nxt_iv_cnt = iv_load_ff;
               nxt_lo_cnt = lo_load_ff;
               nxt_hi_cnt = hi_load_ff;
               nxt_gate   = 1'b0;
            end
         end
         ACQ_RUN: begin
            if (stop_edge) nxt_gate = 1'b1;
            // reload on terminal count, 0 spans 65536
            if (base_tick) nxt_iv_cnt = (iv_cnt_ff == ONE16) ? iv_load_ff : iv_cnt_ff - ONE16;
            nxt_conv = conv_fire;
            if (counted) begin
               nxt_lo_cnt = lo_cnt_ff - ONE16;
               if (cnt32_ff && lo_cnt_ff == ONE16) nxt_hi_cnt = hi_cnt_ff - ONE16;
            end
            // Errors and terminal count all halt the sequence
            if (done || ovfl_set || ovrn_set) nxt_st = ACQ_IDLE;
         end
      endcase
      nxt_act = (nxt_st == ACQ_RUN);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff         <= ACQ_IDLE;
         iv_cnt_ff     <= WORD_RST;
         lo_cnt_ff     <= WORD_RST;
         hi_cnt_ff     <= WORD_RST;
         gate_ff       <= 1'b0;
         conv_ff       <= 1'b0;
         act_ff        <= 1'b0;
         ovfl_ff       <= 1'b0;
         ovrn_ff       <= 1'b0;
         stop_prev_ff  <= 1'b1;
         start_prev_ff <= 1'b1;
         src_prev_ff   <= 1'b1;
      end else begin
         st_ff         <= nxt_st;
         iv_cnt_ff     <= nxt_iv_cnt;
         lo_cnt_ff     <= nxt_lo_cnt;
         hi_cnt_ff     <= nxt_hi_cnt;
         gate_ff       <= nxt_gate;
         conv_ff       <= nxt_conv;
         act_ff        <= nxt_act;
         ovfl_ff       <= nxt_ovfl;
         ovrn_ff       <= nxt_ovrn;
         stop_prev_ff  <= stop_trigger_input;
         start_prev_ff <= start_trigger_input_n;
         src_prev_ff   <= fifth_source_input;
      end
   end

   // APB answer prepared in the setup cycle so the access phase needs no wait
   always_comb begin
      nxt_pready  = setup;
      nxt_pslverr = setup && !is_mapped(paddr);
      nxt_prdata  = prdata_ff;
      if (setup && !pwrite) begin
         nxt_prdata = 32'h0000_0000;
         case (paddr)
            ADDR_STATUS: begin
               nxt_prdata[ST_AVAIL] = !f.empty;
               nxt_prdata[ST_OVFL]  = ovfl_ff;
               nxt_prdata[ST_OVRN]  = ovrn_ff;
               nxt_prdata[ST_RUN]   = act_ff;
               nxt_prdata[ST_GATED] = gate_ff;
            end
            ADDR_CTRL:    nxt_prdata[CTRL_CNT32] = cnt32_ff;
            ADDR_FIFO:    nxt_prdata[DATA_W-1:0] = f.head;
            ADDR_MUXGAIN: nxt_prdata[GAIN_HI:0] = {gain_ff, 2'h0, chan_ff};
            ADDR_IV_MODE: nxt_prdata[15:0] = iv_mode_ff;
            ADDR_IV_LOAD: nxt_prdata[15:0] = iv_load_ff;
            ADDR_LO_MODE: nxt_prdata[15:0] = lo_mode_ff;
            ADDR_LO_LOAD: nxt_prdata[15:0] = lo_load_ff;
            ADDR_HI_MODE: nxt_prdata[15:0] = hi_mode_ff;
            ADDR_HI_LOAD: nxt_prdata[15:0] = hi_load_ff;
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= 32'h0000_0000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         prdata_ff  <= nxt_prdata;
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   assign prdata        = prdata_ff;
   assign pready        = pready_ff;
   assign pslverr       = pslverr_ff;
   assign convert_pulse = conv_ff;
   assign gain_sel      = gain_ff;
   assign channel_sel   = chan_ff;
   assign acq_active    = act_ff;

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_sw_start;
      wr_acc && (paddr == ADDR_START) && (pwdata[15:0] == WORD_RST) && (st_ff == ACQ_IDLE);
   endsequence
   sequence s_running;
      (st_ff == ACQ_RUN) ##1 acq_active;
   endsequence

   property p_pretrig_hold;
      (st_ff == ACQ_RUN) && !gate_ff && (lo_mode_ff[GATE_HI:GATE_LO] == GATE_LEVEL_HIGH) |=>
         $stable(lo_cnt_ff);
   endproperty
   a_pretrig_hold: assert property (p_pretrig_hold) else $error("sample count moved before stop edge");

   property p_sw_start;
      s_sw_start |=> s_running;
   endproperty
   a_sw_start: assert property (p_sw_start) else $error("software start did not start");

   property p_interval;
      (st_ff == ACQ_RUN) && base_tick && (iv_cnt_ff == ONE16) |=> convert_pulse ##1 !convert_pulse;
   endproperty
   a_interval: assert property (p_interval) else $error("interval pulse wrong");

   property p_single_end;
      !cnt32_ff && counted && (lo_cnt_ff == ONE16) |=> (st_ff == ACQ_IDLE) ##1 !acq_active;
   endproperty
   a_single_end: assert property (p_single_end) else $error("single counter did not end");

   property p_cascade;
      cnt32_ff && counted && (hi_cnt_ff != WORD_RST) && !ovfl_set && !ovrn_set |=> (st_ff == ACQ_RUN);
   endproperty
   a_cascade: assert property (p_cascade) else $error("cascade ended early");

   property p_flush;
      f.flush && !adc_done |=> f.empty;
   endproperty
   a_flush: assert property (p_flush) else $error("clear did not empty buffer");

   // A flush in the same cycle wins over the push, so that case is left out
   property p_avail;
      f.push && !f.flush |=> !f.empty;
   endproperty
   a_avail: assert property (p_avail) else $error("result not available");

   // A pop or flush in the lost result's cycle may legally lower the fill level
   property p_ovfl;
      adc_done && f.full |=> ovfl_ff && (st_ff == ACQ_IDLE) && (f.full || $past(f.pop || f.flush));
   endproperty
   a_ovfl: assert property (p_ovfl) else $error("overflow not flagged");

   property p_ovrn;
      conv_fire && adc_busy |=> ovrn_ff && (st_ff == ACQ_IDLE);
   endproperty
   a_ovrn: assert property (p_ovrn) else $error("overrun not flagged");

   property p_flag_clr;
      clr_wr && !ovfl_set && !ovrn_set |=> !ovfl_ff && !ovrn_ff;
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flags not cleared");

   property p_muxgain;
      !(wr_acc && (paddr == ADDR_MUXGAIN)) |=> $stable(gain_sel) && $stable(channel_sel);
   endproperty
   a_muxgain: assert property (p_muxgain) else $error("gain or channel changed");

   property p_halted;
      (st_ff == ACQ_IDLE) && $past(st_ff == ACQ_IDLE) |-> !convert_pulse;
   endproperty
   a_halted: assert property (p_halted) else $error("conversion while halted");
endmodule : pac_acq_ctrl

// ---- hw/pac_fifo.sv ----
// Purpose: Sixteen-entry result buffer
// Assumes: Pop only when not empty, push only when not full
// Notes:   Flush wins over push and pop in the same cycle
`timescale 1ns/1ps
module pac_fifo
   import pac_pkg::*;
(
   // Clock and reset
   input wire logic  pclk,
   input wire logic  presetn,
   // Buffer port
   pac_fifo_if.buf_side f
);
   logic [DATA_W-1:0] mem [FIFO_DEPTH];
   logic [PTR_W-1:0]  wr_ff, rd_ff, nxt_wr, nxt_rd;
   logic [PTR_W:0]    cnt_ff, nxt_cnt;

   // Pointer and fill level update
   always_comb begin
      nxt_wr  = wr_ff;
      nxt_rd  = rd_ff;
      nxt_cnt = cnt_ff;
      if (f.flush) begin
         nxt_wr  = rd_ff;
         nxt_cnt = '0;
      end else begin
         if (f.push) nxt_wr = wr_ff + 1'b1;
         if (f.pop) nxt_rd = rd_ff + 1'b1;
         nxt_cnt = cnt_ff + (PTR_W+1)'(f.push) - (PTR_W+1)'(f.pop);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         wr_ff  <= nxt_wr;
         rd_ff  <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end

   // Storage has no reset; head shows the word at the read pointer even when empty
   always_ff @(posedge pclk) begin
      if (f.push && !f.flush) begin
         mem[wr_ff] <= f.push_data;
      end
   end

   assign f.full  = (cnt_ff == (PTR_W+1)'(FIFO_DEPTH));
   assign f.empty = (cnt_ff == '0);
   assign f.head  = mem[rd_ff];
endmodule : pac_fifo

// ---- hw/pac_fifo_if.sv ----
// Purpose: Carrier between the controller and its result buffer
// Assumes: Single clock
// Notes:   Push is never issued while full; the controller counts that as loss
`timescale 1ns/1ps
interface pac_fifo_if
   import pac_pkg::*;
();
   logic              push;
   logic [DATA_W-1:0] push_data;
   logic              pop;
   logic              flush;
   logic              full;
   logic              empty;
   logic [DATA_W-1:0] head;
   modport buf_side (input push, input push_data, input pop, input flush,
                     output full, output empty, output head);
   modport user_side (output push, output push_data, output pop, output flush,
                      input full, input empty, input head);
endinterface : pac_fifo_if

// ---- hw/pac_pkg.sv ----
// Purpose: Shared constants and types of the pretrigger acquisition control block
// Assumes: 32-bit APB, byte addresses, 200 MHz pclk
// Notes:   Mode words keep the 16-bit counter layout: gating in [15:13], source in [11:8]
package pac_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_STATUS  = 8'h00;
   localparam logic [7:0] ADDR_CTRL    = 8'h04;
   localparam logic [7:0] ADDR_START   = 8'h08;
   localparam logic [7:0] ADDR_CLEAR   = 8'h0C;
   localparam logic [7:0] ADDR_FIFO    = 8'h10;
   localparam logic [7:0] ADDR_MUXGAIN = 8'h14;
   localparam logic [7:0] ADDR_IV_MODE = 8'h18;
   localparam logic [7:0] ADDR_IV_LOAD = 8'h1C;
   localparam logic [7:0] ADDR_LO_MODE = 8'h20;
   localparam logic [7:0] ADDR_LO_LOAD = 8'h24;
   localparam logic [7:0] ADDR_HI_MODE = 8'h28;
   localparam logic [7:0] ADDR_HI_LOAD = 8'h2C;
   // Field positions
   localparam int ST_AVAIL = 0;
   localparam int ST_OVFL  = 1;
   localparam int ST_OVRN  = 2;
   localparam int ST_RUN   = 3;
   localparam int ST_GATED = 4;
   localparam int CTRL_CNT32 = 0;
   localparam int GAIN_HI = 7;
   localparam int GAIN_LO = 6;
   localparam int CHAN_HI = 3;
   localparam int GATE_HI = 15;
   localparam int GATE_LO = 13;
   localparam int SRC_HI  = 11;
   localparam int SRC_LO  = 8;
   // Mode field codes
   localparam logic [2:0] GATE_LEVEL_HIGH = 3'h4;
   localparam logic [3:0] SRC_FIFTH = 4'h5;
   localparam logic [3:0] SRC_1MHZ  = 4'hB;
   localparam logic [3:0] SRC_100K  = 4'hC;
   localparam logic [3:0] SRC_10K   = 4'hD;
   localparam logic [3:0] SRC_1K    = 4'hE;
   localparam logic [3:0] SRC_100HZ = 4'hF;
   // Reset value and unit step
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [15:0] ONE16    = 16'h0001;
   // Timing
   localparam int CLK_FREQ_HZ = 200_000_000;
   localparam int TB1_FREQ_HZ = 1_000_000;
   localparam int TB1_DIV     = CLK_FREQ_HZ / TB1_FREQ_HZ;
   localparam logic [3:0] DECADE_LAST = 4'h9;
   localparam int NUM_TB = 5;
   // Buffer shape and controller states
   localparam int DATA_W = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int PTR_W = 4;
   typedef enum logic [0:0] {
      ACQ_IDLE = 1'b0,
      ACQ_RUN  = 1'b1
   } pac_state_type;
endpackage : pac_pkg

// ---- hw/pac_tbase.sv ----
// Purpose: Internal timebase ticks at 1 MHz, 100 kHz, 10 kHz, 1 kHz and 100 Hz
// Assumes: pclk at CLK_FREQ_HZ
// Notes:   Each tick is a one-cycle pulse; slower ones coincide with faster ones
`timescale 1ns/1ps
module pac_tbase
   import pac_pkg::*;
(
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // Tick outputs, fastest first
   output logic [NUM_TB-1:0]      tick
);
   logic [7:0] pre_ff, nxt_pre;

   // Prescaler to the fastest timebase
   always_comb begin
      nxt_pre = (pre_ff == 8'(TB1_DIV - 1)) ? 8'h00 : pre_ff + 8'h01;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pre_ff <= 8'h00;
      else pre_ff <= nxt_pre;
   end

   assign tick[0] = (pre_ff == 8'(TB1_DIV - 1));

   // Decade dividers, each counting ticks of the stage before
   for (genvar i = 1; i < NUM_TB; i++) begin : g_dec
      logic [3:0] dec_ff, nxt_dec;
      always_comb begin
         nxt_dec = dec_ff;
         if (tick[i-1]) nxt_dec = (dec_ff == DECADE_LAST) ? 4'h0 : dec_ff + 4'h1;
      end
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) dec_ff <= 4'h0;
         else dec_ff <= nxt_dec;
      end
      assign tick[i] = tick[i-1] && (dec_ff == DECADE_LAST);
   end
endmodule : pac_tbase

// ---- tb/pac_adc_model.sv ----
// Purpose: Converter model at the far side of the block
// Assumes: One conversion per request, busy until done
// Notes:   slow stretches a conversion past the interval
`timescale 1ns/1ps
module pac_adc_model (
   // Clock, reset, mode
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        slow,
   // Converter pins
   input  wire logic        convert_pulse,
   output logic             adc_busy,
   output logic             adc_done,
   output logic [15:0]      adc_data
);
   logic [15:0] val_ff;
   logic [9:0]  cnt_ff;
   // Bus is not held outside the done cycle
   assign adc_data = adc_done ? val_ff : ~val_ff;
   // Busy span, then a one-cycle done pulse
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {adc_busy, adc_done, cnt_ff, val_ff} <= {12'h000, 16'h0100};
      end else begin
         adc_done <= 1'b0;
         if (convert_pulse && !adc_busy) begin
            adc_busy <= 1'b1;
            cnt_ff   <= slow ? 10'h258 : 10'h014;
         end else if (adc_busy) begin
            cnt_ff <= cnt_ff - 10'h001;
            if (cnt_ff == 10'h001) begin
               {adc_busy, adc_done} <= 2'b01;
               val_ff <= val_ff + 16'h0001;
            end
         end
      end
   end
endmodule : pac_adc_model

// ---- tb/tb_pac_acq_ctrl.sv ----
// Purpose: Self-checking bench of the acquisition block
// Assumes: 1 MHz timebase, interval 2, 400 cycles a sample
// Notes:   Flag bits compared as status[2:0]
`timescale 1ns/1ps
module tb_pac_acq_ctrl;
   import pac_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        start_n, stop, slow, busy, done, conv, active;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] adata;
   logic [1:0]  gain;
   logic [3:0]  chan;
   logic [3:0]  src_cnt;
   int          bad_count, check_count, conv_n;

   pac_acq_ctrl u_pac_acq_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .start_trigger_input_n(start_n), .stop_trigger_input(stop), .fifth_source_input(src_cnt[3]),
      .adc_busy(busy), .adc_done(done), .adc_data(adata), .convert_pulse(conv),
      .gain_sel(gain), .channel_sel(chan), .acq_active(active));
   pac_adc_model u_pac_adc_model (.pclk(pclk), .presetn(presetn), .slow(slow), .convert_pulse(conv),
      .adc_busy(busy), .adc_done(done), .adc_data(adata));

   // Clock and conversion tally
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) if (conv === 1'b1) conv_n++;
   // External timebase, one rising edge every 16 cycles, well below pclk/2
   always @(posedge pclk) src_cnt <= src_cnt + 4'h1;

   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask : apb

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask : chk

   task automatic stat(input logic [2:0] e);
      apb(0, ADDR_STATUS, 0);
      chk("status", {29'h0, e}, {29'h0, rd[2:0]});
   endtask : stat

   // Wait out a run; a hang past 20000 cycles fails the active check
   task automatic idle();
      repeat (3) @(posedge pclk);
      for (int i = 0; i < 20000 && active !== 1'b0; i++) @(posedge pclk);
      // Let the last conversion land before any clear, then look off the edge
      repeat (30) @(posedge pclk);
      @(negedge pclk);
      chk("active", 0, {31'h0, active});
   endtask : idle

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict

   // Watchdog, well beyond the 10k cycles of the tests
   initial begin
      repeat (60000) @(posedge pclk);
      bad_count++;
      give_verdict();
   end

   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata, stop, slow, conv_n, src_cnt} = '0;
      {start_n, bad_count, check_count} = {1'b1, 64'h0};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      stat(3'b000);
      apb(1, ADDR_MUXGAIN, 16'h00C5);
      // The register updates at the commit edge, so look half a cycle later
      @(negedge pclk);
      chk("mux", 32'h35, {26'h0, gain, chan});
      apb(1, 8'hFC, 16'h0001);
      chk("slverr", 1, {31'h0, err});
      $display("register test done");
      apb(1, ADDR_IV_MODE, 16'h8B25);
      apb(1, ADDR_IV_LOAD, 16'h0002);
      apb(1, ADDR_LO_MODE, 16'h9025);
      apb(1, ADDR_LO_LOAD, 16'h0003);
      apb(1, ADDR_CLEAR, 0);
      apb(1, ADDR_START, 0);
      wait (conv_n == 2);
      @(posedge pclk) stop <= 1'b1;
      idle();
      chk("conv", 5, conv_n);
      stat(3'b001);
      apb(0, ADDR_FIFO, 0);
      chk("pre", 32'h0101, rd);
      $display("pretrigger test done");
      stop <= 1'b0;
      apb(1, ADDR_CLEAR, 0);
      conv_n = 0;
      apb(1, ADDR_START, 0);
      idle();
      chk("ovfl conv", 17, conv_n);
      stat(3'b011);
      apb(1, ADDR_CLEAR, 1);
      stat(3'b001);
      apb(1, ADDR_CLEAR, 0);
      stat(3'b000);
      $display("overflow test done");
      {slow, start_n} <= 2'b10;
      conv_n = 0;
      repeat (2) @(posedge pclk);
      start_n <= 1'b1;
      idle();
      repeat (700) @(posedge pclk);
      chk("ovrn conv", 2, conv_n);
      stat(3'b101);
      $display("overrun test done");
      // Cascaded count of 3 by the software recipe: low 3-1, high 0+1, paced by the external source
      slow <= 1'b0;
      apb(1, ADDR_IV_MODE, 16'h8525);
      apb(1, ADDR_LO_LOAD, 16'h0002);
      apb(1, ADDR_HI_MODE, 16'h0025);
      apb(1, ADDR_HI_LOAD, 16'h0001);
      apb(1, ADDR_CTRL, 16'h0001);
      apb(1, ADDR_CLEAR, 0);
      conv_n = 0;
      apb(1, ADDR_START, 0);
      stop <= 1'b1;
      idle();
      chk("cascade conv", 3, conv_n);
      stat(3'b001);
      $display("cascade test done");
      give_verdict();
   end
endmodule : tb_pac_acq_ctrl
